// ==== pkg/ddw_params.svh ====
// Constants for the DDR2 write-burst host controller.
// Assumes a 25 MHz system clock and a memory clock of one quarter of it.
`ifndef DDW_PARAMS_SVH
`define DDW_PARAMS_SVH

// ==========================================================
// Clocking
`define DDW_CK_DIV 4
`define DDW_CLK_PS 40000
`define DDW_TCK_PS (`DDW_CLK_PS * `DDW_CK_DIV)
`define DDW_CEIL_CK(ps) (((ps) + `DDW_TCK_PS - 1) / `DDW_TCK_PS)
`define DDW_PH_D1 2'h0
`define DDW_PH_CMD 2'h1
`define DDW_PH_D0 2'h2
`define DDW_PH_RISE 2'h3

// ==========================================================
// Latencies in memory clocks
`define DDW_CL 3
`define DDW_AL 0
`define DDW_RL (`DDW_AL + `DDW_CL)
`define DDW_WL (`DDW_RL - 1)
`define DDW_TRUNC_CK 2
`define DDW_RTW_EXTRA 2
`define DDW_RD_PRE_OFS 2
`define DDW_MIN_WTR 2
`define DDW_MIN_RTP 2

// ==========================================================
// Analog times in picoseconds and derived clock counts
`define DDW_T_WR_PS 15000
`define DDW_T_WTR_PS 7500
`define DDW_T_RTP_PS 7500
`define DDW_T_RAS_PS 40000
`define DDW_T_RP_PS 15000
`define DDW_T_RCD_PS 15000
`define DDW_WR_CK `DDW_CEIL_CK(`DDW_T_WR_PS)
`define DDW_WTR_CK ((`DDW_CEIL_CK(`DDW_T_WTR_PS) > `DDW_MIN_WTR) ? `DDW_CEIL_CK(`DDW_T_WTR_PS) : `DDW_MIN_WTR)
`define DDW_RTP_CK ((`DDW_CEIL_CK(`DDW_T_RTP_PS) > `DDW_MIN_RTP) ? `DDW_CEIL_CK(`DDW_T_RTP_PS) : `DDW_MIN_RTP)
`define DDW_RAS_CK `DDW_CEIL_CK(`DDW_T_RAS_PS)
`define DDW_RP_CK `DDW_CEIL_CK(`DDW_T_RP_PS)
`define DDW_RCD_CK `DDW_CEIL_CK(`DDW_T_RCD_PS)

// ==========================================================
// System-clock delays from command edge to data edges
`define DDW_WDLY (1 + `DDW_CK_DIV * `DDW_WL)
`define DDW_RDLY (5 + `DDW_CK_DIV * `DDW_RL)

// ==========================================================
// Widths, lengths, command codes {CS_N,RAS_N,CAS_N,WE_N}
`define DDW_DQ_W 16
`define DDW_WORD_W 18
`define DDW_FIFO_D 16
`define DDW_CNT_W 5
`define DDW_TMR_W 6
`define DDW_BANKS 8
`define DDW_HALF_BL4 6'h02
`define DDW_HALF_BL8 6'h04
`define DDW_LEN_BL4 4'h4
`define DDW_LEN_BL8 4'h8
`define DDW_CODE_ACT 4'h3
`define DDW_CODE_WR 4'h4
`define DDW_CODE_RD 4'h5
`define DDW_CODE_PRE 4'h2
`define DDW_CODE_NOP 4'h7

`endif

// ==== pkg/ddw_pkg.sv ====
// Types shared by the DDR2 write-burst host controller.
// Assumes the constant header is on the include path.
`include "ddw_params.svh"

package ddw_pkg;

	// ==========================================================
	// User requests
	typedef enum logic [1:0] {DDW_OP_WRITE, DDW_OP_READ, DDW_OP_PRE} ddw_op_t;

	typedef struct packed {
		ddw_op_t op;
		logic [2:0] bank;
		logic [13:0] row;
		logic [9:0] col;
		logic ap;
		logic chop;
	} ddw_cmd_t;

	typedef struct packed {
		logic [`DDW_DQ_W-1:0] data;
		logic [1:0] mask;
	} ddw_wdata_t;

	// ==========================================================
	// Memory command pins
	typedef struct packed {
		logic [3:0] code;
		logic [2:0] ba;
		logic [13:0] addr;
	} ddw_bus_t;

	// ==========================================================
	// Truncation slot tracking
	typedef enum logic [1:0] {ST_NORMAL, ST_GAP, ST_TRUNC} ddw_st_t;

endpackage

// ==== logic/ddw_ctrl.sv ====
// DDR2 host controller for write bursts: command timing, bank tracking, DQ/DQS drive.
// Assumes CLK at 25 MHz, a memory clock made here at CLK/4, and a memory outside
// programmed with CL, AL, WR and the burst length that MODE_BL8 selects.
`timescale 1ns/1ps
`include "ddw_params.svh"

// ==========================================================
// Countdown timer: ready once the loaded spacing has passed
module ddw_tmr (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronised reset, low active
	input wire logic ce, // Clock enable
	input wire logic tick, // One memory clock passed
	input wire logic load, // Raise timer to val
	input wire logic [`DDW_TMR_W-1:0] val, // Spacing in memory clocks
	output logic ready // Spacing satisfied
);
	logic [`DDW_TMR_W-1:0] cnt;
	logic [`DDW_TMR_W-1:0] next_cnt;

	// Longest pending spacing wins
	always_comb begin
		next_cnt = cnt;
		if (tick && cnt != '0)
			next_cnt = cnt - 6'h01;
		if (load && val > next_cnt)
			next_cnt = val;
	end

	// Counter state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= '0;
		else if (ce)
			cnt <= next_cnt;
	end

	assign ready = (cnt <= 6'h01);
endmodule

// ==========================================================
// Write data FIFO with registered ready on the filling side
module ddw_fifo #(
	parameter int W = `DDW_WORD_W,
	parameter int D = `DDW_FIFO_D
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronised reset, low active
	input wire logic ce, // Clock enable
	input wire logic in_valid, // Word offered
	input wire logic [W-1:0] in_data, // Word in
	output logic in_ready, // Room for a word
	output logic out_valid, // Word available
	output logic [W-1:0] out_data, // Head word
	input wire logic out_ready, // Head taken
	output logic [$clog2(D):0] count // Words held
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW:0] wp;
	logic [AW:0] rp;
	logic [AW:0] next_count;
	wire push = ce & in_valid & in_ready;
	wire pop = ce & out_ready & out_valid;

	// Occupancy and flags
	assign out_valid = (count != '0);
	assign out_data = mem[rp[AW-1:0]];
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// Pointers and ready
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else if (ce) begin
			wp <= wp + {{AW{1'b0}}, push};
			rp <= rp + {{AW{1'b0}}, pop};
			count <= next_count;
			in_ready <= (next_count != (AW+1)'(D));
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push)
			mem[wp[AW-1:0]] <= in_data;
	end
endmodule

// ==========================================================
// Top: command scheduler, bank tracking, data engines
module ddw_ctrl (
	input wire logic CLK, // System clock
	input wire logic NRST, // Asynchronous reset, low active
	input wire logic CE, // Clock enable
	input wire logic MODE_BL8, // Burst length eight when high
	input wire logic CMD_VALID, // Request offered
	input wire ddw_pkg::ddw_cmd_t CMD, // Request
	output logic CMD_READY, // Request slot free
	input wire logic WR_VALID, // Write word offered
	input wire ddw_pkg::ddw_wdata_t WR_WORD, // Write word and byte masks
	output logic WR_READY, // Write FIFO has room
	output logic [`DDW_DQ_W-1:0] RD_DATA, // Read element
	output logic RD_VALID, // Read element strobe
	output logic CK, // Memory clock
	output logic CK_N, // Memory clock complement
	output ddw_pkg::ddw_bus_t CMD_BUS, // Command, bank, address pins
	output logic [`DDW_DQ_W-1:0] DQ_O, // Data out
	output logic DQ_OE_N, // Data drive, low active
	input wire logic [`DDW_DQ_W-1:0] DQ_I, // Data in
	output logic [1:0] DM, // Byte masks
	output logic LDQS_O, // Lower strobe out
	output logic LDQS_OE_N, // Lower strobe drive, low active
	output logic UDQS_O, // Upper strobe out
	output logic UDQS_OE_N // Upper strobe drive, low active
);
	logic [1:0] rst_sync;
	logic [1:0] ph;
	ddw_pkg::ddw_cmd_t hc;
	logic held;
	ddw_pkg::ddw_st_t st;
	ddw_pkg::ddw_st_t next_st;
	logic [`DDW_BANKS-1:0] open_q;
	logic [13:0] row_q [0:`DDW_BANKS-1];
	logic [`DDW_BANKS-1:0] act_ok;
	logic [`DDW_BANKS-1:0] pre_ok;
	logic [`DDW_BANKS-1:0] col_ok;
	logic wr_ok;
	logic rd_ok;
	logic [`DDW_CNT_W-1:0] resv;
	logic [`DDW_CNT_W-1:0] f_count;
	logic f_valid;
	ddw_pkg::ddw_wdata_t f_word;
	logic [`DDW_WDLY-1:0] wsr;
	logic [`DDW_RDLY-1:0] rsr;
	logic [3:0] welems;
	logic [3:0] relems;
	logic [`DDW_DQ_W-1:0] dq_s1;
	logic [`DDW_DQ_W-1:0] dq_s2;
	ddw_pkg::ddw_bus_t next_bus;

	// ==========================================================
	// Reset release and phase of the memory clock
	wire rst_n = rst_sync[1];

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			ph <= 2'h0;
		else if (CE)
			ph <= ph + 2'h1;
	end

	// Edge strobes within one memory clock
	wire slot = CE & (ph == `DDW_PH_CMD);
	wire rise_e = CE & (ph == `DDW_PH_RISE);
	wire dat_e = CE & ((ph == `DDW_PH_D0) | (ph == `DDW_PH_D1));

	// Divided memory clock, commands change on its falling edge
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			CK <= 1'b0;
			CK_N <= 1'b1;
		end else if (CE) begin
			CK <= (ph == `DDW_PH_RISE) | (ph == `DDW_PH_D1);
			CK_N <= !((ph == `DDW_PH_RISE) | (ph == `DDW_PH_D1));
		end
	end

	// ==========================================================
	// Request holding register
	wire [2:0] b = hc.bank;
	wire bl8 = MODE_BL8;
	wire is_wr = (hc.op == ddw_pkg::DDW_OP_WRITE);
	wire is_rd = (hc.op == ddw_pkg::DDW_OP_READ);
	wire is_pre = (hc.op == ddw_pkg::DDW_OP_PRE);
	wire row_hit = open_q[b] & (row_q[b] == hc.row);
	wire normal = (st == ddw_pkg::ST_NORMAL);
	wire [`DDW_TMR_W-1:0] half = bl8 ? `DDW_HALF_BL8 : `DDW_HALF_BL4;
	wire [`DDW_CNT_W-1:0] avail = f_count - resv;
	wire [`DDW_CNT_W-1:0] need = bl8 ? `DDW_CNT_W'(`DDW_LEN_BL8) : `DDW_CNT_W'(`DDW_LEN_BL4);
	wire chop = hc.chop & bl8 & !hc.ap;

	// Legal commands for the held request at this slot
	wire do_act = held & !is_pre & !open_q[b] & act_ok[b] & normal;
	wire do_pre = held & open_q[b] & pre_ok[b] & normal & (is_pre | !row_hit);
	wire do_wr = held & is_wr & row_hit & col_ok[b] & wr_ok & (avail >= need) & (st != ddw_pkg::ST_GAP);
	wire do_rd = held & is_rd & row_hit & col_ok[b] & rd_ok & normal;
	wire pre_skip = held & is_pre & !open_q[b] & normal;
	wire go_act = slot & do_act;
	wire go_pre = slot & do_pre;
	wire go_wr = slot & do_wr;
	wire go_rd = slot & do_rd;
	wire go_chop = go_wr & chop;
	wire release_cmd = go_wr | go_rd | (go_pre & is_pre) | (slot & pre_skip);
	wire accept = CE & CMD_READY & CMD_VALID;
	wire next_held = accept ? 1'b1 : (release_cmd ? 1'b0 : held);
	wire cancel = slot & (st == ddw_pkg::ST_TRUNC) & !go_wr;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			held <= 1'b0;
			CMD_READY <= 1'b0;
		end else if (CE) begin
			held <= next_held;
			CMD_READY <= !next_held;
		end
	end

	always_ff @(posedge CLK) begin
		if (accept)
			hc <= CMD;
	end

	// ==========================================================
	// Truncation window: the next write must land exactly two clocks on
	always_comb begin
		next_st = st;
		case (st)
			ddw_pkg::ST_NORMAL: begin
				if (go_chop)
					next_st = ddw_pkg::ST_GAP;
			end
			ddw_pkg::ST_GAP: begin
				if (slot)
					next_st = ddw_pkg::ST_TRUNC;
			end
			ddw_pkg::ST_TRUNC: begin
				if (slot)
					next_st = go_chop ? ddw_pkg::ST_GAP : ddw_pkg::ST_NORMAL;
			end
			default: next_st = ddw_pkg::ST_NORMAL;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			st <= ddw_pkg::ST_NORMAL;
		else if (CE)
			st <= next_st;
	end

	// ==========================================================
	// Spacing values in memory clocks
	wire [`DDW_TMR_W-1:0] wr_rec = `DDW_TMR_W'(`DDW_WL) + half + `DDW_TMR_W'(`DDW_WR_CK);
	wire [`DDW_TMR_W-1:0] rd_pre = `DDW_TMR_W'(`DDW_AL) + half - `DDW_TMR_W'(`DDW_RD_PRE_OFS)
		+ `DDW_TMR_W'(`DDW_RTP_CK);
	wire [`DDW_TMR_W-1:0] rp = `DDW_TMR_W'(`DDW_RP_CK);
	wire [`DDW_TMR_W-1:0] ras = `DDW_TMR_W'(`DDW_RAS_CK);
	wire [`DDW_TMR_W-1:0] pre_val = go_act ? ras : (go_wr ? wr_rec : rd_pre);
	wire [`DDW_TMR_W-1:0] act_val = go_act ? ras + rp : (go_pre ? rp : (go_wr ? wr_rec + rp : rd_pre + rp));
	wire pre_ld = go_act | go_wr | go_rd;
	wire act_ld = go_act | go_pre | ((go_wr | go_rd) & hc.ap);
	wire [`DDW_TMR_W-1:0] wr_val = go_wr ? (chop ? `DDW_TMR_W'(`DDW_TRUNC_CK) : half)
		: half + `DDW_TMR_W'(`DDW_RTW_EXTRA);
	wire [`DDW_TMR_W-1:0] rd_val = go_wr ? `DDW_TMR_W'(`DDW_WL) + half + `DDW_TMR_W'(`DDW_WTR_CK) : half;

	// Per-bank timers
	for (genvar gi = 0; gi < `DDW_BANKS; gi++) begin : g_bank
		wire sel = (b == 3'(gi));
		ddw_tmr u_act (.clk(CLK), .rst_n(rst_n), .ce(CE), .tick(slot), .load(sel & act_ld),
			.val(act_val), .ready(act_ok[gi]));
		ddw_tmr u_pre (.clk(CLK), .rst_n(rst_n), .ce(CE), .tick(slot), .load(sel & pre_ld),
			.val(pre_val), .ready(pre_ok[gi]));
		ddw_tmr u_col (.clk(CLK), .rst_n(rst_n), .ce(CE), .tick(slot), .load(sel & go_act),
			.val(`DDW_TMR_W'(`DDW_RCD_CK)), .ready(col_ok[gi]));
	end

	// Shared column timers
	ddw_tmr u_wr (.clk(CLK), .rst_n(rst_n), .ce(CE), .tick(slot), .load(go_wr | go_rd),
		.val(wr_val), .ready(wr_ok));
	ddw_tmr u_rd (.clk(CLK), .rst_n(rst_n), .ce(CE), .tick(slot), .load(go_wr | go_rd),
		.val(rd_val), .ready(rd_ok));

	// Open and closed banks
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			open_q <= '0;
		else if (CE) begin
			if (go_act)
				open_q[b] <= 1'b1;
			else if (go_pre | ((go_wr | go_rd) & hc.ap))
				open_q[b] <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (go_act)
			row_q[b] <= hc.row;
	end

	// ==========================================================
	// Command pins, updated at the falling memory clock edge
	always_comb begin
		next_bus.code = `DDW_CODE_NOP;
		next_bus.ba = hc.bank;
		next_bus.addr = '0;
		if (go_act) begin
			next_bus.code = `DDW_CODE_ACT;
			next_bus.addr = hc.row;
		end else if (go_pre)
			next_bus.code = `DDW_CODE_PRE;
		else if (go_wr | go_rd) begin
			next_bus.code = go_wr ? `DDW_CODE_WR : `DDW_CODE_RD;
			next_bus.addr = {3'h0, hc.ap, hc.col};
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			CMD_BUS <= '{code: `DDW_CODE_NOP, ba: 3'h0, addr: 14'h0000};
		else if (slot)
			CMD_BUS <= next_bus;
	end

	// ==========================================================
	// Write data FIFO and word reservation
	wire wstart = wsr[`DDW_WDLY-1];
	wire wpre = wsr[`DDW_WDLY-2];
	wire [3:0] wlen = bl8 ? `DDW_LEN_BL8 : `DDW_LEN_BL4;
	wire w_act = dat_e & f_valid & (wstart | (welems != 4'h0));

	ddw_fifo #(.W(`DDW_WORD_W), .D(`DDW_FIFO_D)) u_fifo (
		.clk(CLK), .rst_n(rst_n), .ce(CE),
		.in_valid(WR_VALID), .in_data(WR_WORD), .in_ready(WR_READY),
		.out_valid(f_valid), .out_data(f_word), .out_ready(w_act),
		.count(f_count)
	);

	wire [`DDW_CNT_W-1:0] res_add = go_wr ? (chop ? `DDW_CNT_W'(`DDW_LEN_BL4) : need)
		: (cancel ? `DDW_CNT_W'(`DDW_LEN_BL4) : '0);

	// Words promised to issued bursts but not yet sent
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			resv <= '0;
		else if (CE)
			resv <= resv + res_add - {4'h0, w_act};
	end

	// ==========================================================
	// Write data engine: a new start overrides a truncated burst
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			wsr <= '0;
			welems <= 4'h0;
			DQ_OE_N <= 1'b1;
			DQ_O <= '0;
			DM <= 2'h0;
		end else if (CE) begin
			wsr <= {wsr[`DDW_WDLY-2:0], go_wr};
			if (w_act) begin
				DQ_O <= f_word.data;
				DM <= f_word.mask;
				DQ_OE_N <= 1'b0;
				welems <= (wstart ? wlen : welems) - 4'h1;
			end else if (dat_e)
				DQ_OE_N <= 1'b1;
		end
	end

	// Strobes: preamble, one edge per element, postamble
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			LDQS_O <= 1'b0;
			UDQS_O <= 1'b0;
			LDQS_OE_N <= 1'b1;
			UDQS_OE_N <= 1'b1;
		end else if (slot) begin
			LDQS_O <= 1'b0;
			UDQS_O <= 1'b0;
			if (wpre) begin
				LDQS_OE_N <= 1'b0;
				UDQS_OE_N <= 1'b0;
			end
		end else if (rise_e) begin
			if (!DQ_OE_N) begin
				LDQS_O <= 1'b1;
				UDQS_O <= 1'b1;
			end else begin
				LDQS_OE_N <= 1'b1;
				UDQS_OE_N <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read capture at fixed latency after two synchroniser stages
	wire rstart = rsr[`DDW_RDLY-1];
	wire r_act = dat_e & (rstart | (relems != 4'h0));

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
			rsr <= '0;
			relems <= 4'h0;
			RD_DATA <= '0;
			RD_VALID <= 1'b0;
		end else if (CE) begin
			dq_s1 <= DQ_I;
			dq_s2 <= dq_s1;
			rsr <= {rsr[`DDW_RDLY-2:0], go_rd};
			RD_VALID <= r_act;
			if (r_act) begin
				RD_DATA <= dq_s2;
				relems <= (rstart ? wlen : relems) - 4'h1;
			end
		end
	end
endmodule

// ==== dv/ddw_ctrl_asserts.sv ====
// Checker for the DDR2 write-burst host controller, bound to its top ports.
// Assumes the constant header is on the include path and a single CLK domain.
`timescale 1ns/1ps
`include "ddw_params.svh"

// ==========================================================
// Pin-level timing checks
module ddw_chk (
	input wire logic CLK, // System clock
	input wire logic NRST, // Asynchronous reset, low active
	input wire logic MODE_BL8, // Burst length eight
	input wire logic CK, // Memory clock
	input wire logic CK_N, // Memory clock complement
	input wire ddw_pkg::ddw_bus_t CMD_BUS, // Command pins
	input wire logic DQ_OE_N, // Data drive, low active
	input wire logic LDQS_O, // Lower strobe
	input wire logic LDQS_OE_N, // Lower strobe drive
	input wire logic UDQS_O, // Upper strobe
	input wire logic UDQS_OE_N // Upper strobe drive
);
	logic [3:0] prev_code;
	logic [5:0] since_wr;
	logic [5:0] since_rd;
	logic [2:0] wr_ba;
	logic [2:0] rd_ba;

	// New pin commands
	wire new_cmd = CMD_BUS.code != prev_code;
	wire wr_iss = new_cmd && CMD_BUS.code == `DDW_CODE_WR;
	wire rd_iss = new_cmd && CMD_BUS.code == `DDW_CODE_RD;
	wire pre_iss = new_cmd && CMD_BUS.code == `DDW_CODE_PRE;

	// Age of the latest write and read, saturating
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			prev_code <= `DDW_CODE_NOP;
			since_wr <= 6'h3F;
			since_rd <= 6'h3F;
			wr_ba <= 3'h0;
			rd_ba <= 3'h0;
		end else begin
			prev_code <= CMD_BUS.code;
			since_wr <= wr_iss ? 6'h00 : since_wr + {5'h00, since_wr != 6'h3F};
			since_rd <= rd_iss ? 6'h00 : since_rd + {5'h00, since_rd != 6'h3F};
			wr_ba <= wr_iss ? CMD_BUS.ba : wr_ba;
			rd_ba <= rd_iss ? CMD_BUS.ba : rd_ba;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// ==========================================================
	// Assertions
	chk_cmd_ck_fall: assert property ($changed(CMD_BUS) |-> $fell(CK))
		else $error("command pins moved away from a clock fall");
	chk_wr_preamble: assert property (wr_iss |-> ##8 (!LDQS_OE_N && !LDQS_O))
		else $error("strobe not driven low before first rise");
	chk_wr_first_rise: assert property (wr_iss |-> ##10 $rose(LDQS_O))
		else $error("first strobe rise not at write latency");
	chk_lane_match: assert property ((LDQS_O == UDQS_O) && (LDQS_OE_N == UDQS_OE_N))
		else $error("byte lane strobes differ");
	chk_ck_compl: assert property (CK_N == !CK)
		else $error("memory clock pair not complementary");
	chk_post_release: assert property ($rose(DQ_OE_N) |-> (!LDQS_O && !LDQS_OE_N) ##1 $rose(LDQS_OE_N))
		else $error("postamble missing after data release");
	chk_wr_gap: assert property (wr_iss |=> !wr_iss [*7])
		else $error("writes closer than two memory clocks");
	chk_wtr_wait: assert property (rd_iss |-> since_wr >= (MODE_BL8 ? 6'd31 : 6'd23))
		else $error("read too soon after write");
	chk_wr_recov: assert property (pre_iss && CMD_BUS.ba == wr_ba |-> since_wr >= (MODE_BL8 ? 6'd27 : 6'd19))
		else $error("precharge before write recovery");
	chk_rd_pre: assert property (pre_iss && CMD_BUS.ba == rd_ba |-> since_rd >= (MODE_BL8 ? 6'd15 : 6'd7))
		else $error("precharge too soon after read");

	// Main scenarios reached
	cover property (wr_iss && MODE_BL8);
	cover property (rd_iss);
	cover property (pre_iss);
endmodule

bind ddw_ctrl ddw_chk u_chk (.CLK(CLK), .NRST(NRST), .MODE_BL8(MODE_BL8), .CK(CK), .CK_N(CK_N), .CMD_BUS(CMD_BUS),
	.DQ_OE_N(DQ_OE_N), .LDQS_O(LDQS_O), .LDQS_OE_N(LDQS_OE_N), .UDQS_O(UDQS_O), .UDQS_OE_N(UDQS_OE_N));

// ==== dv/ddw_mem_model.sv ====
// Behavioural DDR2 device facing the host controller.
// Assumes column addresses below 64 and a fixed read latency from the header.
`timescale 1ns/1ps
`include "ddw_params.svh"

// ==========================================================
// Device model
module ddw_mem_model (
	input wire logic ck, // Memory clock
	input wire ddw_pkg::ddw_bus_t cmd_bus, // Command pins
	input wire logic bl8, // Burst length eight
	input wire logic [15:0] dq, // Data wire
	input wire logic [1:0] dm, // Byte masks
	input wire logic ldqs, // Lower strobe
	input wire logic ldqs_oe_n, // Lower strobe drive
	input wire logic udqs, // Upper strobe
	input wire logic udqs_oe_n, // Upper strobe drive
	output logic [15:0] dq_out, // Read data driven
	output int viol // Protocol faults seen
);
	logic [15:0] mem [0:7][0:63];
	logic [7:0] open_b = 8'h00;
	int wq_b[$];
	int wq_c[$];
	int wq_n[$];
	int ck_n = 0;
	int last_wr = -9;
	int lk = 0;
	int uk = 0;

	initial begin
		viol = 0;
		dq_out = 16'hFFFF;
		foreach (mem[b, c]) mem[b][c] = 16'h0000;
	end

	// Read burst at read latency; writes land one clock earlier
	task automatic drive_rd(input int b, input int c);
		int n;
		n = bl8 ? 8 : 4;
		#(`DDW_TCK_PS * `DDW_RL / 1000 + 5);
		for (int k = 0; k < n; k++) begin
			dq_out = mem[b][(c + k) % 64];
			#(`DDW_TCK_PS / 2000);
		end
		dq_out = ~dq_out;
	endtask

	// Command decode on each memory clock rise
	always @(posedge ck) begin
		ck_n++;
		case (cmd_bus.code)
			`DDW_CODE_ACT: begin
				if (open_b[cmd_bus.ba]) viol++;
				open_b[cmd_bus.ba] = 1'b1;
			end
			`DDW_CODE_WR: begin
				if (!open_b[cmd_bus.ba]) viol++;
				if (bl8 && ck_n - last_wr == 2 && wq_n.size() > 0) wq_n[wq_n.size() - 1] = 4;
				last_wr = ck_n;
				wq_b.push_back(cmd_bus.ba);
				wq_c.push_back(cmd_bus.addr[5:0]);
				wq_n.push_back(bl8 ? 8 : 4);
				if (cmd_bus.addr[10]) open_b[cmd_bus.ba] = 1'b0;
			end
			`DDW_CODE_RD: begin
				if (!open_b[cmd_bus.ba]) viol++;
				fork
					drive_rd(cmd_bus.ba, cmd_bus.addr[5:0]);
				join_none
				if (cmd_bus.addr[10]) open_b[cmd_bus.ba] = 1'b0;
			end
			`DDW_CODE_PRE: open_b[cmd_bus.ba] = 1'b0;
			default: ;
		endcase
	end

	// Per-lane capture on both strobe edges; idle strobes are ignored
	always @(ldqs) begin
		if (!ldqs_oe_n && wq_n.size() > 0) begin
			if (!dm[0]) mem[wq_b[0]][(wq_c[0] + lk) % 64][7:0] = dq[7:0];
			lk++;
			if (lk == wq_n[0] && uk == wq_n[0]) pop_burst();
		end
	end
	always @(udqs) begin
		if (!udqs_oe_n && wq_n.size() > 0) begin
			if (!dm[1]) mem[wq_b[0]][(wq_c[0] + uk) % 64][15:8] = dq[15:8];
			uk++;
			if (lk == wq_n[0] && uk == wq_n[0]) pop_burst();
		end
	end

	// Next burst follows directly
	task automatic pop_burst();
		void'(wq_b.pop_front());
		void'(wq_c.pop_front());
		void'(wq_n.pop_front());
		lk = 0;
		uk = 0;
	endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the DDR2 write-burst host controller.
// Assumes the device model and checker are compiled alongside.
`timescale 1ns/1ps
`include "ddw_params.svh"

// ==========================================================
// Bench top
module tb;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic MODE_BL8 = 1'b0;
	logic CMD_VALID = 1'b0;
	logic WR_VALID = 1'b0;
	ddw_pkg::ddw_cmd_t CMD = '0;
	ddw_pkg::ddw_wdata_t WR_WORD = '0;
	logic CMD_READY, WR_READY, RD_VALID, CK, DQ_OE_N, LDQS_O, LDQS_OE_N, UDQS_O, UDQS_OE_N;
	logic [15:0] RD_DATA, DQ_O, dq_mem;
	logic [1:0] DM;
	ddw_pkg::ddw_bus_t CMD_BUS;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	int viol;
	logic [15:0] rdq[$];
	// Shared data wire
	wire [15:0] dq_w = DQ_OE_N ? dq_mem : DQ_O;

	ddw_ctrl DUT (.CLK(CLK), .NRST(NRST), .CE(1'b1), .MODE_BL8(MODE_BL8), .CMD_VALID(CMD_VALID), .CMD(CMD),
		.CMD_READY(CMD_READY), .WR_VALID(WR_VALID), .WR_WORD(WR_WORD), .WR_READY(WR_READY), .RD_DATA(RD_DATA),
		.RD_VALID(RD_VALID), .CK(CK), .CK_N(), .CMD_BUS(CMD_BUS), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .DQ_I(dq_w),
		.DM(DM), .LDQS_O(LDQS_O), .LDQS_OE_N(LDQS_OE_N), .UDQS_O(UDQS_O), .UDQS_OE_N(UDQS_OE_N));
	ddw_mem_model u_mem (.ck(CK), .cmd_bus(CMD_BUS), .bl8(MODE_BL8), .dq(dq_w), .dm(DM), .ldqs(LDQS_O),
		.ldqs_oe_n(LDQS_OE_N), .udqs(UDQS_O), .udqs_oe_n(UDQS_OE_N), .dq_out(dq_mem), .viol(viol));

	always #20 CLK = ~CLK;

	// Read elements and hang guard
	always @(posedge CLK) begin
		if (RD_VALID === 1'b1) rdq.push_back(RD_DATA);
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("MISMATCH at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One request, held until taken
	task automatic req(input ddw_pkg::ddw_op_t op, input logic [2:0] b, input logic [9:0] c, input logic ap,
		input logic chop);
		@(posedge CLK);
		#1 CMD = '{op: op, bank: b, row: 14'h0005, col: c, ap: ap, chop: chop};
		CMD_VALID = 1'b1;
		do @(posedge CLK); while (CMD_READY !== 1'b1);
		#1 CMD_VALID = 1'b0;
	endtask

	// Write words base+i, mask m on the second word
	task automatic push(input int n, input logic [15:0] base, input logic [1:0] m);
		for (int i = 0; i < n; i++) begin
			WR_WORD = '{data: base + i[15:0], mask: (i == 1) ? m : 2'b00};
			WR_VALID = 1'b1;
			do @(posedge CLK); while (WR_READY !== 1'b1);
			#1;
		end
		WR_VALID = 1'b0;
	endtask

	// Read back n words; the first nv are first+i, word 1 ANDed with keep1, the rest untouched
	task automatic rd_chk(input logic [2:0] b, input logic [9:0] c, input logic [15:0] first, input int nv,
		input int n, input logic ap, input logic [15:0] keep1);
		rdq.delete();
		req(ddw_pkg::DDW_OP_READ, b, c, ap, 1'b0);
		for (int t = 0; t < 200 && rdq.size() < n; t++) @(posedge CLK);
		#1;
		chk(rdq.size(), n);
		for (int i = 0; i < n; i++) chk(rdq[i], i < nv ? (first + i[15:0]) & (i == 1 ? keep1 : 16'hFFFF) : 16'h0000);
	endtask

	task automatic sc_basic();
		push(4, 16'h1000, 2'b01);
		req(ddw_pkg::DDW_OP_WRITE, 3'h1, 10'h008, 1'b0, 1'b0);
		rd_chk(3'h1, 10'h008, 16'h1000, 4, 4, 1'b0, 16'hFF00);
	endtask

	task automatic sc_seamless();
		push(8, 16'h2000, 2'b10);
		req(ddw_pkg::DDW_OP_WRITE, 3'h2, 10'h000, 1'b0, 1'b0);
		req(ddw_pkg::DDW_OP_WRITE, 3'h2, 10'h004, 1'b0, 1'b0);
		req(ddw_pkg::DDW_OP_PRE, 3'h2, 10'h000, 1'b0, 1'b0);
		rd_chk(3'h2, 10'h000, 16'h2000, 4, 4, 1'b0, 16'h00FF);
		rd_chk(3'h2, 10'h004, 16'h2004, 4, 4, 1'b0, 16'hFFFF);
	endtask

	task automatic sc_chop();
		MODE_BL8 = 1'b1;
		push(12, 16'h3000, 2'b00);
		req(ddw_pkg::DDW_OP_WRITE, 3'h3, 10'h000, 1'b0, 1'b1);
		req(ddw_pkg::DDW_OP_WRITE, 3'h3, 10'h010, 1'b0, 1'b0);
		rd_chk(3'h3, 10'h000, 16'h3000, 4, 8, 1'b0, 16'hFFFF);
		rd_chk(3'h3, 10'h010, 16'h3004, 8, 8, 1'b0, 16'hFFFF);
		@(posedge CLK);
		#1 MODE_BL8 = 1'b0;
	endtask

	task automatic sc_ap();
		push(4, 16'h4000, 2'b00);
		req(ddw_pkg::DDW_OP_WRITE, 3'h4, 10'h000, 1'b1, 1'b0);
		rd_chk(3'h4, 10'h000, 16'h4000, 4, 4, 1'b1, 16'hFFFF);
		req(ddw_pkg::DDW_OP_PRE, 3'h4, 10'h000, 1'b0, 1'b0);
		req(ddw_pkg::DDW_OP_PRE, 3'h1, 10'h000, 1'b0, 1'b0);
		rd_chk(3'h1, 10'h008, 16'h1000, 4, 4, 1'b0, 16'hFF00);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge CLK);
		#1 chk(CMD_BUS.code, `DDW_CODE_NOP);
		chk(DQ_OE_N, 1'b1);
		NRST = 1'b1;
		sc_basic();
		sc_seamless();
		sc_chop();
		sc_ap();
		chk(viol, 0);
		tally_and_finish();
	end
endmodule
